// ===== logic/ebc_bus_controller.sv
/*
  External bus area controller: APB register file, master arbiter,
  external bus sequencer with waits, DRAM strobes, burst ROM, idle
  gap, write buffer, bus release.
  Assumes all inputs synchronous to CORE_CLK; masters hold request
  until their done pulse.
*/
`timescale 1ns/1ps
`default_nettype none
module ebc_bus_controller
  import ebc_pkg::*;
(
  // Clock, reset, enable, strap
  input wire logic CORE_CLK,
  input wire logic RST_N,
  input wire logic CLK_EN,
  input wire logic HW_STANDBY,
  input wire logic [2:0] MODE,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [17:0] PADDR,
  input wire logic [31:0] PWDATA,
  output var logic [31:0] PRDATA,
  output var logic PREADY,
  output var logic PSLVERR,
  // Internal masters: 0 core, 1 DMA, 2 transfer engine
  input wire logic [2:0] MST_REQ,
  input wire logic [2:0] MST_WR,
  input wire logic [2:0] MST_WORD,
  input wire logic [71:0] MST_ADDR,
  input wire logic [47:0] MST_WDATA,
  output var logic [2:0] MST_DONE,
  output var logic [15:0] MST_RDATA,
  // External bus
  output var logic [23:0] EXT_ADDR,
  output var logic [15:0] EXT_DOUT,
  output var logic EXT_DOUT_OE,
  input wire logic [15:0] EXT_DIN,
  output var logic EXT_BUS_OE,
  output var logic ADDRESS_STROBE_N,
  output var logic READ_STROBE_N,
  output var logic HIGH_BYTE_WRITE_N,
  output var logic LOW_BYTE_WRITE_N,
  output var logic [7:0] CHIP_SELECT_N,
  output var logic UPPER_COLUMN_STROBE_N,
  output var logic LOWER_COLUMN_STROBE_N,
  input wire logic WAIT_REQUEST_N,
  // Bus release
  input wire logic BUS_RELEASE_REQUEST_N,
  output var logic BUS_RELEASE_ACK_N,
  output var logic BUS_RETURN_REQUEST_N
);
  logic [7:0] regs_ff [0:NREG-1];
  logic init_ff;
  ebc_state_t st_ff, nxt_st;
  logic [23:0] ad_ff, c_addr, last_ad_ff, w_addr, row;
  logic [15:0] dat_ff, rd_ff, w_wdata, dout;
  logic [1:0] m_ff, win, wc_ff, nxt_wc, int_cnt_ff, int_m_ff, code;
  logic wr_ff, word_ff, two_ff, lastrd_ff, c_wr, c_word, c_two;
  logic [2:0] pend, svc_ff, last_area_ff, c_area, a_area, w_area, nxt_done;
  logic [2:0] rm;
  logic win_ok, w_wr, w_word, w_int, ld, int_go, step, fin, gap, burst;
  logic c_bus8, c_dram, up, lo, act, strb, a_bus8, three, hit, reg_wr;
  logic [7:0] wid, tri_bits, bch, dcr;
  logic [15:0] wcr;

  // ---------------------------------------------------------------
  // Register file
  // ---------------------------------------------------------------
  assign wid = regs_ff[0];
  assign tri_bits = regs_ff[1];
  assign wcr = {regs_ff[2], regs_ff[3]};
  assign bch = regs_ff[4];
  assign dcr = regs_ff[7];
  assign hit = PADDR[17:2] >= IDX_WIDTH && PADDR[17:2] <= IDX_RCONST &&
    PADDR[1:0] == 2'h0;
  assign reg_wr = PSEL && PENABLE && PREADY && PWRITE && hit;

  // Strap caught one enabled edge after release, not under reset
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      init_ff <= 1'b0;
      for (int i = 0; i < NREG; i++) regs_ff[i] <= REG_RST[i];
    end else if (CLK_EN) begin
      init_ff <= 1'b1;
      if (HW_STANDBY || !init_ff) begin
        for (int i = 0; i < NREG; i++) regs_ff[i] <= REG_RST[i];
        if (MODE == MODE_FOUR) regs_ff[0] <= WID_RST_M4;
      end else if (reg_wr) begin
        regs_ff[PADDR[5:2]] <= PWDATA[7:0];
      end
    end
  end

  // Zero-wait APB answer, ready in the first cycle of the access phase
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA <= 32'h0;
    end else if (CLK_EN) begin
      PREADY <= PSEL && !PENABLE;
      if (PSEL && !PENABLE) begin
        PSLVERR <= !hit;
        PRDATA <= hit ? {24'h0, regs_ff[PADDR[5:2]]} : 32'h0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Arbiter: DMA over transfer engine over core
  // ---------------------------------------------------------------
  assign pend = MST_REQ & ~svc_ff & ~MST_DONE;
  always_comb begin
    win_ok = |pend;
    if (pend[MST_DMA]) win = MST_DMA;
    else if (pend[MST_XFER]) win = MST_XFER;
    else win = MST_CPU;
  end
  assign w_addr = MST_ADDR[24*win +: 24];
  assign w_wdata = MST_WDATA[16*win +: 16];
  assign w_wr = MST_WR[win];
  assign w_word = MST_WORD[win];
  assign w_area = w_addr[23:AREA_LSB];
  assign w_int = w_addr >= INT_BASE;
  assign ld = st_ff == S_IDLE && win_ok && !w_int && BUS_RELEASE_REQUEST_N;
  assign int_go = win_ok && w_int && int_cnt_ff == 2'h0;
  // Gap only for back-to-back cycles; an idle bus cycle clears it
  assign gap = lastrd_ff && ((!w_wr && w_area != last_area_ff && bch[BCH_ICIS1]) ||
    (w_wr && bch[BCH_ICIS0]));
  assign burst = bch[BCH_BRST_EN] && !w_wr && w_area == 3'h0 && lastrd_ff &&
    last_area_ff == 3'h0 && !(w_word && wid[0]) && (bch[BCH_BRST_EIGHT] ?
    w_addr[23:4] == last_ad_ff[23:4] : w_addr[23:3] == last_ad_ff[23:3]);

  // ---------------------------------------------------------------
  // Current access fields
  // ---------------------------------------------------------------
  assign a_area = ad_ff[23:AREA_LSB];
  assign a_bus8 = wid[a_area];
  assign three = tri_bits[a_area];
  assign code = wcr[2*a_area +: 2];
  always_comb begin
    c_addr = ad_ff;
    c_wr = wr_ff;
    c_word = word_ff;
    c_two = two_ff;
    if (ld) begin
      c_addr = w_addr;
      c_wr = w_wr;
      c_word = w_word;
      c_two = w_word && wid[w_area];
    end else if (step) begin
      c_addr = {ad_ff[23:1], 1'b1};
      c_two = 1'b0;
    end
  end
  assign c_area = c_addr[23:AREA_LSB];
  assign c_bus8 = wid[c_area];
  assign rm = bch[2:0];
  assign c_dram = (c_area == 3'h2 && rm != 3'h0 && !rm[2]) ||
    (c_area == 3'h3 && (rm == 3'h2 || rm == 3'h3)) ||
    ((c_area == 3'h4 || c_area == 3'h5) && rm == 3'h3);
  assign up = c_bus8 || c_word || !c_addr[0];
  assign lo = !c_bus8 && (c_word || c_addr[0]);
  assign dout = (c_word && !c_bus8) ? dat_ff : (c_word ? (c_addr[0] ?
    {dat_ff[7:0], dat_ff[7:0]} : {dat_ff[15:8], dat_ff[15:8]}) :
    {dat_ff[7:0], dat_ff[7:0]});
  assign row = (dcr[1:0] == 2'h0) ? {8'h00, c_addr[23:8]} : ((dcr[1:0] == 2'h1) ?
    {9'h000, c_addr[23:9]} : {10'h000, c_addr[23:10]});

  // ---------------------------------------------------------------
  // Bus sequencer
  // ---------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    nxt_wc = wc_ff;
    step = 1'b0;
    fin = 1'b0;
    case (st_ff)
      S_IDLE: begin
        if (!BUS_RELEASE_REQUEST_N) nxt_st = S_REL;
        else if (ld && burst) begin
          nxt_st = S_BST;
          nxt_wc = bch[BCH_BRST_TWO] ? 2'h1 : 2'h0;
        end else if (ld && gap) nxt_st = S_GAP;
        else if (ld) nxt_st = S_T1;
      end
      S_GAP: nxt_st = S_T1;
      S_T1: nxt_st = S_T2;
      S_T2: begin
        if (three && (code != 2'h0 || !WAIT_REQUEST_N)) begin
          nxt_st = S_TW;
          nxt_wc = code;
        end else if (three) nxt_st = S_T3;
        else fin = 1'b1;
      end
      S_TW: begin
        if (wc_ff > 2'h1 || !WAIT_REQUEST_N) begin
          if (wc_ff != 2'h0) nxt_wc = wc_ff - 2'h1;
        end else nxt_st = S_T3;
      end
      S_T3: fin = 1'b1;
      S_BST: begin
        if (wc_ff != 2'h0) nxt_wc = wc_ff - 2'h1;
        else fin = 1'b1;
      end
      S_REL: if (BUS_RELEASE_REQUEST_N) nxt_st = S_IDLE;
      default: nxt_st = S_IDLE;
    endcase
    // Second byte of a word on an 8-bit area
    if (fin) begin
      step = two_ff;
      nxt_st = two_ff ? S_T1 : S_IDLE;
    end
  end
  assign act = (nxt_st & (S_T1 | S_T2 | S_TW | S_T3 | S_BST)) != 8'h00;
  assign strb = (nxt_st & (S_T2 | S_TW | S_T3 | S_BST)) != 8'h00;

  // State and latched request
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      st_ff <= S_IDLE;
      wc_ff <= 2'h0;
      ad_ff <= 24'h0;
      wr_ff <= 1'b0;
      word_ff <= 1'b0;
      two_ff <= 1'b0;
      m_ff <= MST_CPU;
      dat_ff <= 16'h0;
    end else if (CLK_EN) begin
      st_ff <= nxt_st;
      wc_ff <= nxt_wc;
      ad_ff <= c_addr;
      wr_ff <= c_wr;
      word_ff <= c_word;
      two_ff <= c_two;
      if (ld) begin
        m_ff <= win;
        dat_ff <= w_wdata;
      end
    end
  end

  // Pin drivers, registered from the next state
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ADDRESS_STROBE_N <= 1'b1;
      READ_STROBE_N <= 1'b1;
      HIGH_BYTE_WRITE_N <= 1'b1;
      LOW_BYTE_WRITE_N <= 1'b1;
      CHIP_SELECT_N <= 8'hFF;
      UPPER_COLUMN_STROBE_N <= 1'b1;
      LOWER_COLUMN_STROBE_N <= 1'b1;
      EXT_ADDR <= 24'h0;
      EXT_DOUT <= 16'h0;
      EXT_DOUT_OE <= 1'b0;
      EXT_BUS_OE <= 1'b1;
      BUS_RELEASE_ACK_N <= 1'b1;
      BUS_RETURN_REQUEST_N <= 1'b1;
    end else if (CLK_EN) begin
      ADDRESS_STROBE_N <= !act;
      READ_STROBE_N <= !(strb && !c_wr);
      HIGH_BYTE_WRITE_N <= !(strb && c_wr && (c_dram || up));
      LOW_BYTE_WRITE_N <= !(strb && c_wr && !c_dram && lo);
      CHIP_SELECT_N <= act ? ~(8'h01 << c_area) : 8'hFF;
      UPPER_COLUMN_STROBE_N <= !(strb && c_dram && up);
      LOWER_COLUMN_STROBE_N <= !(strb && c_dram && lo);
      EXT_ADDR <= (c_dram && nxt_st == S_T1) ? row : c_addr;
      EXT_DOUT <= dout;
      EXT_DOUT_OE <= act && c_wr;
      EXT_BUS_OE <= nxt_st != S_REL;
      BUS_RELEASE_ACK_N <= nxt_st != S_REL;
      BUS_RETURN_REQUEST_N <= !(nxt_st == S_REL && win_ok && !w_int);
    end
  end

  // ---------------------------------------------------------------
  // Completion, read data, write buffer, internal path
  // ---------------------------------------------------------------
  always_comb begin
    nxt_done = 3'h0;
    if (ld && w_wr) nxt_done[win] = 1'b1;
    if (fin && !two_ff && !wr_ff) nxt_done[m_ff] = 1'b1;
    if (int_cnt_ff == 2'h1) nxt_done[int_m_ff] = 1'b1;
  end

  // External writes retire at acceptance, so the master can go on inside
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      MST_DONE <= 3'h0;
      MST_RDATA <= 16'h0;
      rd_ff <= 16'h0;
      svc_ff <= 3'h0;
      int_cnt_ff <= 2'h0;
      int_m_ff <= MST_CPU;
    end else if (CLK_EN) begin
      MST_DONE <= nxt_done;
      svc_ff <= (svc_ff | ({2'h0, (ld && !w_wr) || int_go} << win)) & ~nxt_done;
      if (int_go) begin
        int_cnt_ff <= INT_STATES;
        int_m_ff <= win;
      end else if (int_cnt_ff != 2'h0) int_cnt_ff <= int_cnt_ff - 2'h1;
      if (fin && !wr_ff) begin
        if (word_ff && !a_bus8) MST_RDATA <= EXT_DIN;
        else if (word_ff && two_ff) rd_ff <= {EXT_DIN[15:8], 8'h00};
        else if (word_ff) MST_RDATA <= {rd_ff[15:8], EXT_DIN[15:8]};
        else MST_RDATA <= {8'h00, (a_bus8 || !ad_ff[0]) ? EXT_DIN[15:8] : EXT_DIN[7:0]};
      end
    end
  end

  // History for idle gap and burst continuation
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      lastrd_ff <= 1'b0;
      last_area_ff <= 3'h0;
      last_ad_ff <= 24'h0;
    end else if (CLK_EN) begin
      if (fin && !two_ff) begin
        lastrd_ff <= !wr_ff;
        last_area_ff <= a_area;
        last_ad_ff <= ad_ff;
      end else if (st_ff == S_IDLE && !ld) lastrd_ff <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  AST_ONE_SELECT: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    $countones(~CHIP_SELECT_N) <= 1) else $error("two chip selects low");
  AST_IDLE_SELECT: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    (st_ff == S_IDLE || st_ff == S_REL || st_ff == S_GAP) |-> CHIP_SELECT_N == 8'hFF)
    else $error("chip select low without access");
  AST_TWO_STATE: assert property (@(posedge CORE_CLK) disable iff (!RST_N || !CLK_EN)
    (st_ff == S_T2 && !three && !two_ff) |=> st_ff != S_TW && st_ff != S_T3)
    else $error("two-state area took extra states");
  AST_WAIT_THREE: assert property (@(posedge CORE_CLK) disable iff (!RST_N || !CLK_EN)
    (st_ff == S_T2 && three && code == 2'h3) |=> (st_ff == S_TW) [*3])
    else $error("program waits short");
  AST_WAIT_PIN: assert property (@(posedge CORE_CLK) disable iff (!RST_N || !CLK_EN)
    (st_ff == S_TW && !WAIT_REQUEST_N) |=> st_ff == S_TW) else $error("wait pin ignored");
  AST_RELEASE: assert property (@(posedge CORE_CLK) disable iff (!RST_N || !CLK_EN)
    (st_ff == S_IDLE && !BUS_RELEASE_REQUEST_N) |=> !BUS_RELEASE_ACK_N && !EXT_BUS_OE)
    else $error("bus not released");
  AST_RETURN: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    !BUS_RETURN_REQUEST_N |-> !BUS_RELEASE_ACK_N) else $error("return request while owned");
  AST_GAP: assert property (@(posedge CORE_CLK) disable iff (!RST_N || !CLK_EN)
    (ld && gap && !burst) |=> st_ff == S_GAP ##1 st_ff == S_T1) else $error("idle gap missing");
  AST_ARBITER: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    pend[MST_DMA] |-> win == MST_DMA) else $error("priority broken");
  AST_WIDTH_INIT: assert property (@(posedge CORE_CLK) disable iff (!RST_N || !CLK_EN)
    ((!init_ff || HW_STANDBY) && MODE == MODE_FOUR) |=> wid == WID_RST_M4) else $error("width reset wrong");
  AST_WBUF: assert property (@(posedge CORE_CLK) disable iff (!RST_N || !CLK_EN)
    (ld && w_wr) |=> MST_DONE[m_ff]) else $error("write not buffered");
  AST_INT_FIXED: assert property (@(posedge CORE_CLK) disable iff (!RST_N || !CLK_EN)
    int_go |=> ##2 MST_DONE[int_m_ff]) else $error("internal access length");
  AST_CAS_RAS: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    (!UPPER_COLUMN_STROBE_N || !LOWER_COLUMN_STROBE_N) |-> CHIP_SELECT_N != 8'hFF)
    else $error("column strobe without row strobe");
endmodule
`default_nettype wire

// ===== logic/ebc_pkg.sv
/*
  Constants of the external bus area controller: register indices,
  reset values, field positions, master numbers, fixed timing.
  Assumes a 32-bit APB slave port, one register per aligned word.
*/
`default_nettype none
package ebc_pkg;
  localparam int NREG = 10;
  // Printed register offsets, used as word indices
  localparam logic [15:0] IDX_WIDTH = 16'hFED0;
  localparam logic [15:0] IDX_STATES = 16'hFED1;
  localparam logic [15:0] IDX_WAIT_H = 16'hFED2;
  localparam logic [15:0] IDX_WAIT_L = 16'hFED3;
  localparam logic [15:0] IDX_BCFG_H = 16'hFED4;
  localparam logic [15:0] IDX_BCFG_L = 16'hFED5;
  localparam logic [15:0] IDX_MEMCFG = 16'hFED6;
  localparam logic [15:0] IDX_DRAMCFG = 16'hFED7;
  localparam logic [15:0] IDX_RCOUNT = 16'hFED8;
  localparam logic [15:0] IDX_RCONST = 16'hFED9;
  // Reset values in index order
  localparam logic [7:0] REG_RST [0:NREG-1] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF,
    8'hD0, 8'h3C, 8'h00, 8'h00, 8'h00, 8'hFF};
  localparam logic [7:0] WID_RST_M4 = 8'h00;
  localparam logic [2:0] MODE_FOUR = 3'h4;
  // Bus config high fields
  localparam int BCH_ICIS1 = 7;
  localparam int BCH_ICIS0 = 6;
  localparam int BCH_BRST_EN = 5;
  localparam int BCH_BRST_TWO = 4;
  localparam int BCH_BRST_EIGHT = 3;
  // Area decode: 2 MB per area
  localparam int AREA_LSB = 21;
  // On-chip space, fixed state count
  localparam logic [23:0] INT_BASE = 24'hFFC000;
  localparam logic [1:0] INT_STATES = 2'h2;
  // Masters
  localparam logic [1:0] MST_CPU = 2'h0;
  localparam logic [1:0] MST_DMA = 2'h1;
  localparam logic [1:0] MST_XFER = 2'h2;
  typedef enum logic [7:0] {
    S_IDLE = 8'h01, S_T1 = 8'h02, S_T2 = 8'h04, S_TW = 8'h08,
    S_T3 = 8'h10, S_GAP = 8'h20, S_REL = 8'h40, S_BST = 8'h80
  } ebc_state_t;
endpackage
`default_nettype wire

// ===== test/ebc_bus_controller_tb.sv
/*
  Self-checking bench of the bus controller: APB register access,
  master requests, external memory model, bus release.
  Assumes the package constants and a 200 MHz core clock.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_errors++; \
  $display("unexpected at %0t: got %h expected %h", $time, a, b); end end
module ebc_bus_controller_tb;
  import ebc_pkg::*;
  logic CORE_CLK, RST_N, CLK_EN, HW_STANDBY, PSEL, PENABLE, PWRITE;
  logic [2:0] MODE, MST_REQ, MST_WR, MST_WORD, MST_DONE, cs3;
  logic [17:0] PADDR;
  logic [31:0] PWDATA, PRDATA, rd;
  logic PREADY, PSLVERR, EXT_DOUT_OE, EXT_BUS_OE, ADDRESS_STROBE_N, READ_STROBE_N;
  logic HIGH_BYTE_WRITE_N, LOW_BYTE_WRITE_N, UPPER_COLUMN_STROBE_N, LOWER_COLUMN_STROBE_N;
  logic WAIT_REQUEST_N, BUS_RELEASE_REQUEST_N, BUS_RELEASE_ACK_N, BUS_RETURN_REQUEST_N;
  logic [71:0] MST_ADDR;
  logic [47:0] MST_WDATA;
  logic [15:0] MST_RDATA, EXT_DOUT, EXT_DIN;
  logic [23:0] EXT_ADDR, a_first;
  logic [7:0] CHIP_SELECT_N, cs_seen;
  logic [1:0] cas_seen;
  logic [3:0] wl;
  logic as_q, rd_q, oe_seen;
  int n_errors, n_tests, as_cnt, rd_cnt, lat, l2, l3, k;

  ebc_bus_controller dut (.CORE_CLK(CORE_CLK), .RST_N(RST_N), .CLK_EN(CLK_EN), .HW_STANDBY(HW_STANDBY),
    .MODE(MODE), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .MST_REQ(MST_REQ), .MST_WR(MST_WR),
    .MST_WORD(MST_WORD), .MST_ADDR(MST_ADDR), .MST_WDATA(MST_WDATA), .MST_DONE(MST_DONE),
    .MST_RDATA(MST_RDATA), .EXT_ADDR(EXT_ADDR), .EXT_DOUT(EXT_DOUT), .EXT_DOUT_OE(EXT_DOUT_OE),
    .EXT_DIN(EXT_DIN), .EXT_BUS_OE(EXT_BUS_OE), .ADDRESS_STROBE_N(ADDRESS_STROBE_N),
    .READ_STROBE_N(READ_STROBE_N), .HIGH_BYTE_WRITE_N(HIGH_BYTE_WRITE_N),
    .LOW_BYTE_WRITE_N(LOW_BYTE_WRITE_N), .CHIP_SELECT_N(CHIP_SELECT_N),
    .UPPER_COLUMN_STROBE_N(UPPER_COLUMN_STROBE_N), .LOWER_COLUMN_STROBE_N(LOWER_COLUMN_STROBE_N),
    .WAIT_REQUEST_N(WAIT_REQUEST_N), .BUS_RELEASE_REQUEST_N(BUS_RELEASE_REQUEST_N),
    .BUS_RELEASE_ACK_N(BUS_RELEASE_ACK_N), .BUS_RETURN_REQUEST_N(BUS_RETURN_REQUEST_N));

  ebc_ext_memory mem_i (.clk(CORE_CLK), .addr(EXT_ADDR), .rd_n(READ_STROBE_N), .hi_wr_n(HIGH_BYTE_WRITE_N),
    .lo_wr_n(LOW_BYTE_WRITE_N), .dout(EXT_DOUT), .wait_len(wl), .din(EXT_DIN), .wait_n(WAIT_REQUEST_N));

  // -----------------------------------------------------------------
  // Clock, monitor, watchdog
  // -----------------------------------------------------------------
  initial begin
    CORE_CLK = 1'b0;
    forever #2.5 CORE_CLK = ~CORE_CLK;
  end

  // Collects which selects and strobes went low since the last clear
  always @(posedge CORE_CLK) begin
    cs_seen |= ~CHIP_SELECT_N;
    cs3 |= ~{READ_STROBE_N, HIGH_BYTE_WRITE_N, LOW_BYTE_WRITE_N};
    cas_seen |= ~{UPPER_COLUMN_STROBE_N, LOWER_COLUMN_STROBE_N};
    oe_seen |= EXT_DOUT_OE;
    // Address seen as the strobe falls; a DRAM area shows its row here
    if (as_q && !ADDRESS_STROBE_N) begin
      as_cnt++;
      a_first = EXT_ADDR;
    end
    // Counts read strobe falls only, so an unbroken strobe chain counts as one
    if (rd_q && !READ_STROBE_N) rd_cnt++;
    as_q = ADDRESS_STROBE_N;
    rd_q = READ_STROBE_N;
  end

  // Whole run is a few hundred cycles; this bound only cuts a hang
  initial begin
    #200us;
    n_errors++;
    complete_run();
  end

  // -----------------------------------------------------------------
  // Tasks
  // -----------------------------------------------------------------
  task automatic complete_run();
    $display("n_tests %0d n_errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // One APB transfer; request held until PREADY is sampled high
  task automatic apb(input logic wr, input logic [15:0] idx, input logic [31:0] d);
    @(posedge CORE_CLK);
    PSEL <= 1'b1; PENABLE <= 1'b0; PWRITE <= wr; PADDR <= {idx, 2'b00}; PWDATA <= d;
    @(posedge CORE_CLK);
    PENABLE <= 1'b1;
    // Only the watchdog ends a wait that never sees ready
    do begin @(posedge CORE_CLK); end while (PREADY !== 1'b1);
    rd = PRDATA;
    PSEL <= 1'b0; PENABLE <= 1'b0;
  endtask

  // One master request; lat counts edges until the done pulse
  task automatic mrun(input int m, input logic wr, input logic wd, input logic [23:0] a,
                      input logic [15:0] d);
    @(posedge CORE_CLK);
    MST_REQ[m] <= 1'b1; MST_WR[m] <= wr; MST_WORD[m] <= wd;
    MST_ADDR[24*m+:24] <= a; MST_WDATA[16*m+:16] <= d;
    lat = 0;
    do begin @(posedge CORE_CLK); lat++; end while (MST_DONE[m] !== 1'b1);
    MST_REQ[m] <= 1'b0;
  endtask

  task automatic clr();
    @(negedge CORE_CLK);
    cs_seen = 8'h00; cs3 = 3'b000; as_cnt = 0;
    cas_seen = 2'b00;
    rd_cnt = 0;
    oe_seen = 1'b0;
  endtask

  // -----------------------------------------------------------------
  // Main sequence
  // -----------------------------------------------------------------
  initial begin
    n_errors = 0; n_tests = 0; as_q = 1'b1; wl = 4'h0;
    rd_q = 1'b1;
    RST_N = 1'b0; CLK_EN = 1'b1; HW_STANDBY = 1'b0; MODE = 3'h5;
    PSEL = 1'b0; PENABLE = 1'b0; PWRITE = 1'b0; PADDR = '0; PWDATA = '0;
    MST_REQ = '0; MST_WR = '0; MST_WORD = '0; MST_ADDR = '0; MST_WDATA = '0;
    BUS_RELEASE_REQUEST_N = 1'b1;
    repeat (4) @(posedge CORE_CLK);
    RST_N <= 1'b1;
    repeat (2) @(posedge CORE_CLK);
    // Reset values, mode five gives an all-ones width register
    for (int i = 0; i < NREG; i++) begin
      apb(1'b0, IDX_WIDTH + 16'(i), 32'h0);
      `CHK(rd, {24'h0, REG_RST[i]})
    end
    apb(1'b0, 16'hFEDA, 32'h0);
    `CHK(PSLVERR, 1'b1)
    // Sixteen-bit, two-state areas; every area owns its own select
    apb(1'b1, IDX_WIDTH, 32'h00);
    apb(1'b1, IDX_STATES, 32'h00);
    for (int a = 0; a < 8; a++) begin
      clr();
      mrun(0, 1'b0, 1'b1, 24'(a) << AREA_LSB, 16'h0);
      `CHK(cs_seen, 8'h01 << a)
      `CHK(as_cnt, 1)
      `CHK(cs3, 3'b100)
    end
    mrun(0, 1'b0, 1'b1, 24'h200000, 16'h0);
    l2 = lat;
    clr();
    mrun(0, 1'b0, 1'b1, INT_BASE, 16'h0);
    `CHK(lat, int'(INT_STATES) + 2)
    `CHK(cs_seen, 8'h00)
    // Wait input ignored for two-state areas
    wl = 4'h3;
    mrun(0, 1'b0, 1'b1, 24'h200000, 16'h0);
    `CHK(lat, l2)
    // Three-state areas with program wait codes zero, two and three
    wl = 4'h0;
    apb(1'b1, IDX_STATES, 32'hFF);
    apb(1'b1, IDX_WAIT_L, 32'hF3);
    mrun(0, 1'b0, 1'b1, 24'h200000, 16'h0);
    l3 = lat;
    `CHK(l3, l2 + 1)
    // Internal space keeps its count whatever the area settings say
    mrun(0, 1'b0, 1'b1, INT_BASE, 16'h0);
    `CHK(lat, int'(INT_STATES) + 2)
    apb(1'b1, IDX_WAIT_L, 32'hFB);
    mrun(0, 1'b0, 1'b1, 24'h200000, 16'h0);
    `CHK(lat, l3 + 2)
    apb(1'b1, IDX_WAIT_L, 32'hFF);
    mrun(0, 1'b0, 1'b1, 24'h200000, 16'h0);
    `CHK(lat, l3 + 3)
    apb(1'b1, IDX_WAIT_L, 32'hF3);
    wl = 4'h2;
    mrun(0, 1'b0, 1'b1, 24'h200000, 16'h0);
    `CHK(lat, l3 + 2)
    wl = 4'h0;
    // Eight-bit area splits a word into two bus cycles
    apb(1'b1, IDX_WIDTH, 32'hFF);
    clr();
    mrun(0, 1'b0, 1'b1, 24'h200000, 16'h0);
    `CHK(rd_cnt, 2)
    apb(1'b1, IDX_WIDTH, 32'h00);
    apb(1'b1, IDX_STATES, 32'h00);
    // Buffered writes on both lanes, then the low lane alone
    clr();
    mrun(0, 1'b1, 1'b1, 24'h200004, 16'hA55A);
    `CHK(lat, l2 - 2)
    repeat (6) @(posedge CORE_CLK);
    `CHK(cs3, 3'b011)
    `CHK(oe_seen, 1'b1)
    clr();
    mrun(0, 1'b1, 1'b0, 24'h200005, 16'h003C);
    repeat (6) @(posedge CORE_CLK);
    `CHK(cs3, 3'b001)
    mrun(0, 1'b0, 1'b1, 24'h200004, 16'h0);
    `CHK(MST_RDATA, 16'hA53C)
    // Core and DMA together: DMA is served first
    @(posedge CORE_CLK);
    MST_REQ <= 3'b011; MST_WR <= 3'b000; MST_WORD <= 3'b011;
    MST_ADDR <= {24'h0, 24'h200000, 24'h400002};
    k = 0;
    do begin @(posedge CORE_CLK); k++; end while (MST_DONE === 3'b000);
    `CHK(MST_DONE, 3'b010)
    MST_REQ <= 3'b001;
    k = 0;
    do begin @(posedge CORE_CLK); k++; end while (MST_DONE[0] !== 1'b1);
    `CHK(MST_DONE, 3'b001)
    // Core read to another area right after the DMA read: one idle state
    `CHK(k, 4)
    MST_REQ <= 3'b000;
    // Area two as DRAM: its select is the row strobe, row address first
    apb(1'b1, IDX_BCFG_H, 32'hD1);
    clr();
    mrun(0, 1'b0, 1'b1, 24'h400000, 16'h0);
    `CHK(cs_seen, 8'h04)
    `CHK(cas_seen, 2'b11)
    `CHK(a_first, 24'h400000 >> 8)
    `CHK(oe_seen, 1'b0)
    // External master takes the bus; a core access asks for it back
    @(posedge CORE_CLK);
    BUS_RELEASE_REQUEST_N <= 1'b0;
    repeat (3) @(posedge CORE_CLK);
    `CHK(BUS_RELEASE_ACK_N, 1'b0)
    `CHK(EXT_BUS_OE, 1'b0)
    `CHK(CHIP_SELECT_N, 8'hFF)
    fork
      mrun(0, 1'b0, 1'b1, 24'h200000, 16'h0);
      begin
        repeat (5) @(posedge CORE_CLK);
        `CHK(BUS_RETURN_REQUEST_N, 1'b0)
        BUS_RELEASE_REQUEST_N <= 1'b1;
      end
    join
    `CHK(BUS_RELEASE_ACK_N, 1'b1)
    // Hardware standby in mode four reloads every register
    @(posedge CORE_CLK);
    HW_STANDBY <= 1'b1; MODE <= MODE_FOUR;
    repeat (3) @(posedge CORE_CLK);
    HW_STANDBY <= 1'b0;
    apb(1'b0, IDX_WIDTH, 32'h0);
    `CHK(rd, {24'h0, WID_RST_M4})
    apb(1'b0, IDX_STATES, 32'h0);
    `CHK(rd, 32'hFF)
    complete_run();
  end
endmodule
`default_nettype wire

// ===== test/ebc_ext_memory.sv
/*
  Behavioural memory on the external parallel bus: sixteen words,
  byte-lane writes, optional wait stretch on reads.
  Assumes the controller's strobes are registered to CORE_CLK.
*/
`timescale 1ns/1ps
`default_nettype none
module ebc_ext_memory (
  // Clock
  input wire logic clk,
  // Bus from the controller
  input wire logic [23:0] addr,
  input wire logic rd_n,
  input wire logic hi_wr_n,
  input wire logic lo_wr_n,
  input wire logic [15:0] dout,
  // Wait cycles asked per read, zero for a fast part
  input wire logic [3:0] wait_len,
  // Answer to the controller
  output logic [15:0] din,
  output logic wait_n
);
  logic [15:0] mem [0:15];
  logic [15:0] last_ff;
  logic [3:0] rd_cnt_ff;

  // -----------------------------------------------------------------
  // Storage
  // -----------------------------------------------------------------
  // Cleared store, so reads before writes are predictable
  initial begin
    for (int i = 0; i < 16; i++) mem[i] = 16'h0000;
  end

  // Byte lanes written separately by their own strobe
  always @(posedge clk) begin
    if (!hi_wr_n) mem[addr[4:1]][15:8] <= dout[15:8];
    if (!lo_wr_n) mem[addr[4:1]][7:0] <= dout[7:0];
    if (!rd_n) last_ff <= mem[addr[4:1]];
    rd_cnt_ff <= rd_n ? 4'h0 : rd_cnt_ff + 4'h1;
  end

  // Released data lines show inverted data, never a stale match
  assign din = !rd_n ? mem[addr[4:1]] : ~last_ff;
  assign wait_n = !(!rd_n && (rd_cnt_ff < wait_len));
endmodule
`default_nettype wire
